// ===== core/rst_seq_map.svh
// Purpose: constants for the reset and brown-out sequencer
// Assumes: 250 MHz system clock
// Notes: times in their own units, delay and filter counts derived, pin release count given in cycles
`ifndef RST_SEQ_MAP_SVH
`define RST_SEQ_MAP_SVH
`define CLK_PERIOD_PS 4000
`define POWER_UP_DELAY_TIMER_TIME_MS 64
`define POWER_UP_DELAY_TIMER_CYCLES ((`POWER_UP_DELAY_TIMER_TIME_MS * 64'd1000000000) / `CLK_PERIOD_PS)
`define FILTER_TIME_NS 1000
`define FILTER_CYCLES ((`FILTER_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define PIN_RELEASE_CYCLES 10
`define BOR_MODE_ON 2'h3
`define BOR_MODE_NOSLEEP 2'h2
`define BOR_MODE_SW 2'h1
`define BOR_MODE_OFF 2'h0
`endif

// ===== core/rst_seq_pkg.sv
// Purpose: types for the reset and brown-out sequencer
// Assumes: nothing
// Notes: reset request sources grouped in one struct
package rst_seq_pkg;
  typedef struct packed {
    logic external_reset_pin;
    logic watchdog_timeout_reset;
    logic reset_instr;
    logic stack_overflow;
    logic stack_underflow;
    logic prog_mode_exit;
    logic low_power_brownout_reset;
  } rst_src_t;
  typedef enum logic [1:0] {
    ST_HOLD,
    ST_DELAY,
    ST_PIN_WAIT,
    ST_RUN
  } seq_state_t;
endpackage

// ===== core/reset_and_brownout_sequencer.sv
// Purpose: merge reset sources into a synchronous core reset
// Assumes: monitor inputs synchronous to clk
// Notes: power-up delay, brown-out filter and ready waits
`timescale 1ns/1ps
`default_nettype none
`include "rst_seq_map.svh"
module reset_and_brownout_sequencer
  import rst_seq_pkg::*;
#(
  parameter longint POWER_UP_DELAY_TIMER_CYCLES = `POWER_UP_DELAY_TIMER_CYCLES,
  parameter int FILTER_CYCLES = `FILTER_CYCLES,
  parameter int PIN_CYCLES = `PIN_RELEASE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_low,
  input wire logic supply_below_bor,
  input wire logic brownout_circuit_ready,
  input wire logic [1:0] brownout_mode_sel,
  input wire logic sw_brownout_enable,
  input wire logic power_up_delay_enable_n,
  input wire logic brownout_level_sel,
  input wire logic sleep_active,
  input wire logic wake_req,
  input wire rst_src_t rst_src,
  output logic core_reset_n,
  output logic brownout_active,
  output logic brownout_ready_status,
  output logic brownout_level,
  output logic wake_grant,
  output logic brownout_reset_flag
);

  initial begin
    if (POWER_UP_DELAY_TIMER_CYCLES < 1 || FILTER_CYCLES < 1 || PIN_CYCLES < 1) begin
      $error("counts must be at least one");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Brown-out enable and filter
  logic bor_en;
  logic [31:0] filt_r, filt_nxt;
  logic bor_trip_r, bor_trip_nxt;
  logic wait_ready;

  always_comb begin
    case (brownout_mode_sel)
      `BOR_MODE_ON: bor_en = 1'b1;
      `BOR_MODE_NOSLEEP: bor_en = !sleep_active;
      `BOR_MODE_SW: bor_en = sw_brownout_enable;
      default: bor_en = 1'b0;
    endcase
    wait_ready = bor_en;
    filt_nxt = 32'h0;
    bor_trip_nxt = 1'b0;
    if (bor_en && supply_below_bor) begin
      if (filt_r >= 32'(FILTER_CYCLES)) begin
        filt_nxt = filt_r;
        bor_trip_nxt = 1'b1;
      end else begin
        filt_nxt = filt_r + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_r <= 32'h0;
      bor_trip_r <= 1'b0;
    end else begin
      filt_r <= filt_nxt;
      bor_trip_r <= bor_trip_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power-up delay timer
  logic [39:0] power_up_delay_timer_r, power_up_delay_timer_nxt;
  logic power_up_delay_timer_busy_r, power_up_delay_timer_busy_nxt;
  logic supply_hold;

  always_comb begin
    supply_hold = por_low || bor_trip_r;
    power_up_delay_timer_nxt = power_up_delay_timer_r;
    power_up_delay_timer_busy_nxt = power_up_delay_timer_busy_r;
    if (supply_hold) begin
      power_up_delay_timer_nxt = 40'h0;
      power_up_delay_timer_busy_nxt = !power_up_delay_enable_n;
    end else if (power_up_delay_timer_busy_r) begin
      if (power_up_delay_timer_r >= 40'(POWER_UP_DELAY_TIMER_CYCLES - 1)) begin
        power_up_delay_timer_busy_nxt = 1'b0;
      end else begin
        power_up_delay_timer_nxt = power_up_delay_timer_r + 40'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_up_delay_timer_r <= 40'h0;
      power_up_delay_timer_busy_r <= 1'b1;
    end else begin
      power_up_delay_timer_r <= power_up_delay_timer_nxt;
      power_up_delay_timer_busy_r <= power_up_delay_timer_busy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Release sequence
  seq_state_t state_r, state_nxt;
  logic [7:0] pin_cnt_r, pin_cnt_nxt;
  logic other_src;
  logic core_reset_n_nxt;
  logic bor_ready_ok;

  always_comb begin
    other_src = rst_src.watchdog_timeout_reset || rst_src.reset_instr
      || rst_src.stack_overflow || rst_src.stack_underflow
      || rst_src.prog_mode_exit || rst_src.low_power_brownout_reset;
    bor_ready_ok = !wait_ready || (brownout_circuit_ready && !supply_below_bor);
    state_nxt = state_r;
    pin_cnt_nxt = pin_cnt_r;
    if (supply_hold || other_src) begin
      state_nxt = ST_HOLD;
    end else begin
      case (state_r)
        ST_HOLD: state_nxt = ST_DELAY;
        ST_DELAY: begin
          if (!power_up_delay_timer_busy_r && bor_ready_ok) begin
            state_nxt = ST_PIN_WAIT;
            pin_cnt_nxt = 8'h0;
          end
        end
        ST_PIN_WAIT: begin
          if (rst_src.external_reset_pin) begin
            pin_cnt_nxt = 8'h0;
          end else if (pin_cnt_r >= 8'(PIN_CYCLES - 1)) begin
            state_nxt = ST_RUN;
          end else begin
            pin_cnt_nxt = pin_cnt_r + 8'h1;
          end
        end
        default: begin
          if (rst_src.external_reset_pin) begin
            state_nxt = ST_PIN_WAIT;
            pin_cnt_nxt = 8'h0;
          end
        end
      endcase
    end
    core_reset_n_nxt = (state_nxt == ST_RUN);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_HOLD;
      pin_cnt_r <= 8'h0;
      core_reset_n <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pin_cnt_r <= pin_cnt_nxt;
      core_reset_n <= core_reset_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status and wake
  logic wake_ok;

  always_comb begin
    // Mode 11 wakes at once; others wait for ready when enabled awake
    if (brownout_mode_sel == `BOR_MODE_ON) begin
      wake_ok = 1'b1;
    end else if (brownout_mode_sel == `BOR_MODE_NOSLEEP) begin
      wake_ok = brownout_circuit_ready;
    end else begin
      wake_ok = !bor_en || brownout_circuit_ready;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      brownout_active <= 1'b0;
      brownout_ready_status <= 1'b0;
      brownout_level <= 1'b0;
      wake_grant <= 1'b0;
      brownout_reset_flag <= 1'b0;
    end else begin
      brownout_active <= bor_en;
      brownout_ready_status <= bor_en && brownout_circuit_ready;
      brownout_level <= brownout_level_sel;
      wake_grant <= sleep_active && wake_req && wake_ok;
      brownout_reset_flag <= bor_trip_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_por_holds;
    @(posedge clk) disable iff (!rst_n) por_low |=> !core_reset_n;
  endproperty
  a_por_holds: assert property (p_por_holds) else $error("reset not held on por");

  property p_power_up_delay_timer_holds;
    @(posedge clk) disable iff (!rst_n) power_up_delay_timer_busy_r |=> !core_reset_n;
  endproperty
  a_power_up_delay_timer_holds: assert property (p_power_up_delay_timer_holds) else $error("reset released in delay");

  property p_bypass;
    @(posedge clk) disable iff (!rst_n)
      (supply_hold && power_up_delay_enable_n) |=> !power_up_delay_timer_busy_r;
  endproperty
  a_bypass: assert property (p_bypass) else $error("delay not bypassed");

  property p_power_up_delay_timer_stays;
    @(posedge clk) disable iff (!rst_n) supply_hold |=> power_up_delay_timer_r == 40'h0;
  endproperty
  a_power_up_delay_timer_stays: assert property (p_power_up_delay_timer_stays) else $error("delay ran during hold");

  property p_src;
    @(posedge clk) disable iff (!rst_n) other_src |=> !core_reset_n;
  endproperty
  a_src: assert property (p_src) else $error("source did not reset");

  property p_off_mode;
    @(posedge clk) disable iff (!rst_n)
      brownout_mode_sel == `BOR_MODE_OFF |=> !brownout_active;
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("off mode active");

  property p_sleep10;
    @(posedge clk) disable iff (!rst_n)
      (brownout_mode_sel == `BOR_MODE_NOSLEEP && sleep_active) |=> !brownout_active;
  endproperty
  a_sleep10: assert property (p_sleep10) else $error("mode 10 active in sleep");

  property p_level;
    @(posedge clk) disable iff (!rst_n) 1'b1 |=> brownout_level == $past(brownout_level_sel);
  endproperty
  a_level: assert property (p_level) else $error("level select lost");

  property p_pin;
    @(posedge clk) disable iff (!rst_n)
      (state_r == ST_PIN_WAIT && rst_src.external_reset_pin) |=> !core_reset_n [*2];
  endproperty
  a_pin: assert property (p_pin) else $error("pin release too fast");

  property p_ready;
    @(posedge clk) disable iff (!rst_n)
      brownout_ready_status |-> $past(brownout_circuit_ready);
  endproperty
  a_ready: assert property (p_ready) else $error("ready without circuit");

endmodule
`default_nettype wire

// ===== dv/supply_monitor_model.sv
// Purpose: supply monitors beside the sequencer
// Assumes: supply ramps for 5 cycles after reset
// Notes: ready lags its request by 2 cycles
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dip,
  input wire logic rdy_en,
  output logic por_low,
  output logic supply_below_bor,
  output logic brownout_circuit_ready
);
  logic [2:0] ramp_r;
  logic [1:0] rdy_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_r <= 3'h0;
      rdy_r <= 2'h0;
    end else begin
      if (ramp_r != 3'h5) ramp_r <= ramp_r + 3'h1;
      rdy_r <= {rdy_r[0], rdy_en};
    end
  end
  assign por_low = (ramp_r != 3'h5);
  assign supply_below_bor = dip | por_low;
  assign brownout_circuit_ready = rdy_r[1];
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Purpose: self-checking bench for the reset sequencer
// Assumes: short delay 20, filter 3, pin wait 10
// Notes: inputs driven by NBA at the rising edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
  import rst_seq_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, dip = 1'b0, rdy_en = 1'b1;
  logic [1:0] mode = 2'h3;
  logic sw_en = 1'b0, pde_n = 1'b0, lvl = 1'b0, slp = 1'b0, wk = 1'b0;
  rst_src_t src = '0;
  logic por_low, below, ready, core_reset_n, act, rdy_st, level, grant, trip;
  int err_count = 0, cmp_count = 0, cyc = 0;
  logic [1:0] t_mode [6] = '{2'h3, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0};
  logic t_sw [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic t_slp [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  logic t_act [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  always #2 clk = ~clk;
  supply_monitor_model PM (.clk(clk), .rst_n(rst_n), .dip(dip), .rdy_en(rdy_en),
    .por_low(por_low), .supply_below_bor(below), .brownout_circuit_ready(ready));
  reset_and_brownout_sequencer #(.POWER_UP_DELAY_TIMER_CYCLES(20), .FILTER_CYCLES(3), .PIN_CYCLES(10)) DUT (
    .clk(clk), .rst_n(rst_n), .por_low(por_low), .supply_below_bor(below),
    .brownout_circuit_ready(ready), .brownout_mode_sel(mode), .sw_brownout_enable(sw_en),
    .power_up_delay_enable_n(pde_n), .brownout_level_sel(lvl), .sleep_active(slp),
    .wake_req(wk), .rst_src(src), .core_reset_n(core_reset_n), .brownout_active(act),
    .brownout_ready_status(rdy_st), .brownout_level(level), .wake_grant(grant),
    .brownout_reset_flag(trip));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_run(input int lim);
    for (int i = 0; i < lim && core_reset_n !== 1'b1; i++) step(1);
    `CHK(core_reset_n, 1'b1)
  endtask
  task automatic long_dip();
    @(posedge clk);
    dip <= 1'b1;
    step(8);
    `CHK(trip, 1'b1)
    `CHK(core_reset_n, 1'b0)
    @(posedge clk);
    dip <= 1'b0;
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    step(10);
    `CHK(core_reset_n, 1'b0)
    @(posedge clk);
    rst_n <= 1'b1;
    step(25);
    `CHK(core_reset_n, 1'b0)
    wait_run(80);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      mode <= t_mode[i];
      sw_en <= t_sw[i];
      slp <= t_slp[i];
      lvl <= i[0];
      step(4);
      `CHK(act, t_act[i])
      `CHK(rdy_st, t_act[i])
      `CHK(level, i[0])
    end
    @(posedge clk);
    mode <= 2'h2;
    slp <= 1'b1;
    wk <= 1'b1;
    rdy_en <= 1'b0;
    step(5);
    `CHK(grant, 1'b0)
    @(posedge clk);
    rdy_en <= 1'b1;
    step(5);
    `CHK(grant, 1'b1)
    @(posedge clk);
    mode <= 2'h3;
    rdy_en <= 1'b0;
    step(5);
    `CHK(grant, 1'b1)
    @(posedge clk);
    slp <= 1'b0;
    wk <= 1'b0;
    mode <= 2'h1;
    step(5);
    `CHK(core_reset_n, 1'b1)
    @(posedge clk);
    mode <= 2'h3;
    rdy_en <= 1'b1;
    step(4);
    @(posedge clk);
    dip <= 1'b1;
    step(2);
    @(posedge clk);
    dip <= 1'b0;
    step(3);
    `CHK(trip, 1'b0)
    `CHK(core_reset_n, 1'b1)
    long_dip();
    step(15);
    `CHK(core_reset_n, 1'b0)
    wait_run(80);
    @(posedge clk);
    pde_n <= 1'b1;
    long_dip();
    wait_run(16);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      src <= rst_src_t'(7'h01 << i);
      step(3);
      `CHK(core_reset_n, 1'b0)
      @(posedge clk);
      src <= '0;
      step(8);
      `CHK(core_reset_n, 1'b0)
      wait_run(60);
    end
    complete_run();
  end
endmodule
`default_nettype wire
